// ==== drpl_pkg.sv ====
// Package: constants and carrier types for the refresh postponement limiter
package drpl_pkg;

  localparam int unsigned DRPL_CLK_HZ = 20_000_000;
  localparam int unsigned DRPL_THR_W = 5;
  localparam int unsigned DRPL_CNT_W = 6;
  localparam int unsigned DRPL_RATIO_W = 4;
  localparam int unsigned DRPL_RATIO_RESCALE = 7;
  // Refresh interval, in ns, and derived cycles (rounded down)
  localparam int unsigned DRPL_TREFI_NS = 3_900;
  localparam int unsigned DRPL_TREFI_CYC = (DRPL_TREFI_NS * (DRPL_CLK_HZ / 1_000_000)) / 1_000;
  localparam int unsigned DRPL_TMR_W = 16;
  localparam logic [DRPL_THR_W-1:0] DRPL_HIGH_RST = 5'h0_013;
  localparam logic [DRPL_THR_W-1:0] DRPL_NORM_RST = 5'h0_012;
  localparam logic [DRPL_THR_W-1:0] DRPL_PBC_RST = 5'h0_011;
  localparam logic [DRPL_THR_W-1:0] DRPL_MAXI_RST = 5'h0_008;

  typedef struct packed {
    logic [DRPL_THR_W-1:0] high_limit;
    logic [DRPL_THR_W-1:0] normal_limit;
    logic [DRPL_THR_W-1:0] per_bank_continuous_limit;
    logic [DRPL_THR_W-1:0] refresh_cmds_max_per_interval;
  } drpl_thr_type;

  typedef struct packed {
    logic urgent;
    logic force_refresh;
    logic per_bank_continuous;
  } drpl_stat_type;

  typedef enum logic [1:0] {
    DRPL_ST_CONFIG = 2'b00,
    DRPL_ST_INIT = 2'b01,
    DRPL_ST_MISSION = 2'b10
  } drpl_state_type;

endpackage

// ==== drpl_interval_timer.sv ====
// Refresh interval timer, reloadable on a frequency switch
`timescale 1ns/1ps
module drpl_interval_timer
  import drpl_pkg::*;
#(
  parameter int unsigned PERIOD = DRPL_TREFI_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic reload,
  input wire logic [DRPL_TMR_W-1:0] reload_value,
  output logic tick
);

  localparam logic [DRPL_TMR_W-1:0] LAST = DRPL_TMR_W'(PERIOD - 1);

  logic [DRPL_TMR_W-1:0] count_reg;
  logic [DRPL_TMR_W-1:0] count_next;
  logic [DRPL_TMR_W-1:0] last_reg;
  logic [DRPL_TMR_W-1:0] last_next;
  logic tick_reg;
  logic tick_next;

  always_comb begin
    count_next = count_reg;
    last_next = last_reg;
    tick_next = 1'b0;
    if (reload) begin
      // Every later window keeps the scaled length, not only the current one
      count_next = reload_value;
      last_next = reload_value;
    end else if (run) begin
      if (count_reg == '0) begin
        count_next = last_reg;
        tick_next = 1'b1;
      end else begin
        count_next = count_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= LAST;
      last_reg <= LAST;
      tick_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      last_reg <= last_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule

// ==== drpl_top.sv ====
// Refresh postponement limiter: deferred-refresh backlog and urgency control
// Notes on behaviour
// RULE1 - Never defer more refreshes than allowed, also right after a down-switch.
// RULE2 - On a down-switch, reload the rolling window counters scaled to the new clock.
// RULE3 - Dynamic switch enable at zero blocks all frequency switches.
// RULE4 - Thresholds programmed before init; frozen once init completes.
// RULE5 - Host programs each threshold at the lowest value of all planned switches.
// RULE6 - Ratio at least 7, per-bank on: high 19, normal 18, continuous 17.
// RULE7 - Ratio at least 7, per-bank off: high 18, normal 17.
// RULE8 - Ratio below 7: high 21; continuous limit below normal when per-bank on.
// RULE9 - Normal limit always strictly below the high limit.
// RULE10 - Host sets maximum refresh commands per interval to 8.
// RULE11 - Continuous limit ignored while per-bank refresh is disabled.
// RULE12 - Urgent at normal limit; forced refresh ahead of traffic at high limit.
`timescale 1ns/1ps
module drpl_top
  import drpl_pkg::*;
#(
  parameter int unsigned TREFI_CYCLES = DRPL_TREFI_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dynamic_freq_switch_enable,
  input wire logic per_bank_refresh_enable,
  input wire drpl_thr_type thr_in,
  input wire logic init_start,
  input wire logic freq_switch_req,
  input wire logic [DRPL_RATIO_W-1:0] freq_ratio,
  input wire logic refresh_issued,
  output drpl_stat_type status,
  output logic init_done,
  output logic freq_switch_ack,
  output logic [DRPL_CNT_W-1:0] backlog,
  output logic [DRPL_THR_W-1:0] issued_in_interval
);

  // ------------------------------------------------------------
  // Threshold capture and init sequencing
  // ------------------------------------------------------------
  drpl_state_type state_reg;
  drpl_state_type state_next;
  drpl_thr_type thr_reg;
  drpl_thr_type thr_next;
  logic init_done_reg;
  logic init_done_next;

  always_comb begin
    state_next = state_reg;
    thr_next = thr_reg;
    init_done_next = init_done_reg;
    unique case (state_reg)
      DRPL_ST_CONFIG: begin
        thr_next = thr_in;
        if (init_start) begin
          state_next = DRPL_ST_INIT;
        end
      end
      DRPL_ST_INIT: begin
        // Capture already closed in CONFIG on the init_start cycle; later writes have no effect
        state_next = DRPL_ST_MISSION; // RULE4
        init_done_next = 1'b1;
      end
      DRPL_ST_MISSION: begin
        thr_next = thr_reg; // RULE4
      end
      default: begin
        state_next = DRPL_ST_CONFIG;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= DRPL_ST_CONFIG;
      thr_reg <= '{DRPL_HIGH_RST, DRPL_NORM_RST, DRPL_PBC_RST, DRPL_MAXI_RST};
      init_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      thr_reg <= thr_next;
      init_done_reg <= init_done_next;
    end
  end

  // ------------------------------------------------------------
  // Frequency switch handling
  // ------------------------------------------------------------
  logic switch_go;
  logic down_switch;
  logic ack_reg;
  logic ack_next;
  logic [DRPL_TMR_W-1:0] reload_value;
  logic [DRPL_TMR_W-1:0] period_reg;
  logic [DRPL_TMR_W-1:0] period_next;
  logic [DRPL_TMR_W-1:0] scaled;
  logic tick;

  // Switch only honoured in mission mode with switching enabled
  assign switch_go = freq_switch_req && dynamic_freq_switch_enable && init_done_reg; // RULE3
  assign down_switch = switch_go && (freq_ratio > DRPL_RATIO_W'(1));

  // Window length in cycles of the present clock; a chain of
  // down-switches divides the current length, not the base one
  always_comb begin
    scaled = period_reg / DRPL_TMR_W'(freq_ratio);
    period_next = period_reg;
    if (down_switch) begin
      // Never below one cycle, or reload_value would wrap to the full 16-bit count
      if (scaled == '0) begin
        period_next = DRPL_TMR_W'(1);
      end else begin
        period_next = scaled; // RULE2
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_reg <= DRPL_TMR_W'(TREFI_CYCLES);
    end else begin
      period_reg <= period_next;
    end
  end

  assign reload_value = period_next - 1'b1; // RULE2

  always_comb begin
    ack_next = switch_go;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
    end
  end

  drpl_interval_timer #(
    .PERIOD(TREFI_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .run(init_done_reg),
    .reload(down_switch),
    .reload_value(reload_value),
    .tick(tick)
  );

  // ------------------------------------------------------------
  // Backlog and per-interval issue count
  // ------------------------------------------------------------
  logic [DRPL_CNT_W-1:0] backlog_reg;
  logic [DRPL_CNT_W-1:0] backlog_next;
  logic [DRPL_THR_W-1:0] issued_reg;
  logic [DRPL_THR_W-1:0] issued_next;
  logic [DRPL_CNT_W-1:0] high_w;
  logic [DRPL_CNT_W-1:0] norm_w;
  logic [DRPL_CNT_W-1:0] pbc_w;
  logic take;

  assign high_w = DRPL_CNT_W'(thr_reg.high_limit);
  assign norm_w = DRPL_CNT_W'(thr_reg.normal_limit);
  assign pbc_w = DRPL_CNT_W'(thr_reg.per_bank_continuous_limit);
  // Extra issues per interval capped, else the backlog could be drained by bursts
  assign take = refresh_issued && (backlog_reg != '0) &&
    (issued_reg < thr_reg.refresh_cmds_max_per_interval);

  always_comb begin
    backlog_next = backlog_reg;
    issued_next = issued_reg;
    if (take) begin
      issued_next = issued_reg + 1'b1;
    end
    if (tick) begin
      issued_next = '0;
    end
    if (down_switch) begin
      // Reloaded window starts fresh; backlog kept so no deferral is forgotten
      issued_next = '0; // RULE1
    end
    if (tick && !take) begin
      // Saturate at the high limit; forced refresh keeps it there
      if (backlog_reg < high_w) begin
        backlog_next = backlog_reg + 1'b1; // RULE1
      end
    end else if (take && !tick) begin
      backlog_next = backlog_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      backlog_reg <= '0;
      issued_reg <= '0;
    end else begin
      backlog_reg <= backlog_next;
      issued_reg <= issued_next;
    end
  end

  // ------------------------------------------------------------
  // Urgency outputs
  // ------------------------------------------------------------
  drpl_stat_type stat_reg;
  drpl_stat_type stat_next;

  always_comb begin
    stat_next.urgent = (backlog_next >= norm_w); // RULE12
    stat_next.force_refresh = (backlog_next >= high_w); // RULE12
    stat_next.per_bank_continuous = per_bank_refresh_enable && (backlog_next >= pbc_w); // RULE11
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  assign status = stat_reg;
  assign init_done = init_done_reg;
  assign freq_switch_ack = ack_reg;
  assign backlog = backlog_reg;
  assign issued_in_interval = issued_reg;

endmodule

// ==== drpl_dram_model.sv ====
// Memory device end: takes one refresh command every other cycle on request
`timescale 1ns/1ps
module drpl_dram_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic want,
  output logic refresh_issued
);
  logic refresh_next;
  // Idle cycle between commands, as the device needs recovery time
  always_comb begin
    refresh_next = want && !refresh_issued;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_issued <= 1'b0;
    end else begin
      refresh_issued <= refresh_next;
    end
  end
endmodule

// ==== drpl_asserts.sv ====
// Checker for the refresh postponement limiter
`timescale 1ns/1ps
module drpl_asserts
  import drpl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dynamic_freq_switch_enable,
  input wire logic per_bank_refresh_enable,
  input wire drpl_thr_type thr_in,
  input wire logic freq_switch_req,
  input wire drpl_stat_type status,
  input wire logic init_done,
  input wire logic freq_switch_ack,
  input wire logic [DRPL_CNT_W-1:0] backlog,
  input wire logic init_start
);
  drpl_thr_type thr_reg;
  drpl_thr_type thr_next;
  logic started_reg;
  logic started_next;
  logic sw_ok;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  assign sw_ok = freq_switch_req && dynamic_freq_switch_enable && init_done;
  // Limits as latched on the init_start edge; later writes ignored
  always_comb begin
    started_next = started_reg || init_start;
    thr_next = started_reg ? thr_reg : thr_in;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_reg <= '0;
      started_reg <= 1'b0;
    end else begin
      thr_reg <= thr_next;
      started_reg <= started_next;
    end
  end
  init_seq_a: assert property (!init_done && init_start |-> ##2 init_done)
    else $error("init late");
  init_hold_a: assert property (init_done |=> init_done)
    else $error("init dropped");
  ack_on_a: assert property (sw_ok |=> freq_switch_ack)
    else $error("no ack");
  ack_off_a: assert property (!sw_ok |=> !freq_switch_ack)
    else $error("stray ack");
  cap_a: assert property (init_done |-> backlog <= thr_reg.high_limit)
    else $error("backlog over limit");
  urgent_a: assert property (init_done |-> status.urgent == (backlog >= thr_reg.normal_limit))
    else $error("urgent wrong");
  force_a: assert property (init_done |-> status.force_refresh == (backlog >= thr_reg.high_limit))
    else $error("force wrong");
  pbc_a: assert property (init_done |-> status.per_bank_continuous ==
    ($past(per_bank_refresh_enable) && backlog >= thr_reg.per_bank_continuous_limit))
    else $error("continuous flag wrong");
endmodule
bind drpl_top drpl_asserts chk_i (.clk, .rst_n, .dynamic_freq_switch_enable,
  .per_bank_refresh_enable, .thr_in, .freq_switch_req, .status, .init_done,
  .freq_switch_ack, .backlog, .init_start);

// ==== drpl_top_tb.sv ====
// Self-checking bench for the refresh postponement limiter
`timescale 1ns/1ps
module drpl_top_tb;
  import drpl_pkg::*;
  localparam int unsigned TREFI = 80;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic dynamic_freq_switch_enable = 1'b1;
  logic per_bank_refresh_enable = 1'b1;
  drpl_thr_type thr_in = '0;
  logic init_start = 1'b0;
  logic freq_switch_req = 1'b0;
  logic [DRPL_RATIO_W-1:0] freq_ratio = 4'h1;
  logic want = 1'b0;
  logic refresh_issued;
  drpl_stat_type status;
  logic init_done;
  logic freq_switch_ack;
  logic [DRPL_CNT_W-1:0] backlog;
  logic [DRPL_THR_W-1:0] issued_in_interval;
  int num_errors = 0;
  int n_compared = 0;
  drpl_top #(.TREFI_CYCLES(TREFI)) dut (.clk, .rst_n, .dynamic_freq_switch_enable,
    .per_bank_refresh_enable, .thr_in, .init_start, .freq_switch_req, .freq_ratio,
    .refresh_issued, .status, .init_done, .freq_switch_ack, .backlog, .issued_in_interval);
  drpl_dram_model dram (.clk, .rst_n, .want, .refresh_issued);
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic chk(string what, logic [5:0] exp, logic [5:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wait_bl(logic [5:0] v, int lim);
    int n;
    n = 0;
    while (backlog !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("backlog", v, backlog);
  endtask
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic t_init();
    @(posedge clk);
    thr_in.high_limit <= 5'h13;
    thr_in.normal_limit <= 5'h12;
    thr_in.per_bank_continuous_limit <= 5'h11;
    thr_in.refresh_cmds_max_per_interval <= 5'h08;
    @(posedge clk);
    init_start <= 1'b1;
    @(posedge clk);
    init_start <= 1'b0;
    @(posedge clk);
    #1;
    chk("init_done", 6'h01, {5'h00, init_done});
    // Later values must not take effect
    thr_in <= '{5'h15, 5'h14, 5'h13, 5'h08};
  endtask
  task automatic t_levels();
    wait_bl(6'h12, 19 * TREFI);
    chk("status", 6'h05, {3'h0, status});
    wait_bl(6'h13, TREFI + 2);
    chk("status", 6'h07, {3'h0, status});
    @(posedge clk);
    per_bank_refresh_enable <= 1'b0;
    @(posedge clk);
    #1;
    chk("status", 6'h06, {3'h0, status});
    per_bank_refresh_enable <= 1'b1;
    repeat (2 * TREFI) @(posedge clk);
    #1;
    chk("backlog", 6'h13, backlog);
  endtask
  task automatic t_switch(logic en);
    @(posedge clk);
    dynamic_freq_switch_enable <= en;
    freq_ratio <= 4'h2;
    freq_switch_req <= 1'b1;
    @(posedge clk);
    freq_switch_req <= 1'b0;
    want <= en;
    #1;
    chk("ack", {5'h00, en}, {5'h00, freq_switch_ack});
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_init();
    t_levels();
    t_switch(1'b1);
    repeat (18) @(posedge clk);
    want <= 1'b0;
    @(posedge clk);
    #1;
    chk("issued", 6'h08, {1'b0, issued_in_interval});
    chk("backlog", 6'h0b, backlog);
    wait_bl(6'h0c, 24);
    t_switch(1'b0);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
endmodule
